// File: logic/flag_latch.sv
// Sticky status flags with read-to-clear over AXI4-Lite, plus interrupt.
// Assumes fault levels and the select and debug pins are asynchronous;
// event pulses, watchdog values and mode levels come from aclk logic.
//
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// (RULE1) Latch switch-three short; clear when gone and read
// (RULE2) Latch switch-two short; clear when gone and read
// (RULE3) Parity error flag; read clears it
// (RULE4) Select low over 2 ms sets flag
// (RULE5) Supply two undervoltage; clear when recovered and read
// (RULE6) Supply one overvoltage; clear when recovered and read
// (RULE7) Switch-zero overtemperature; clear when cool and read
// (RULE8) Flash mode watchdog past half sets flag
// (RULE9) Wake on pin one or three flag
// (RULE10) Wake on pin zero or two flag
// (RULE11) Serial command wake, regulator on, flag
// (RULE12) Forced wake-up source flag
// (RULE13) Interrupt service timeout flag
// (RULE14) Regulator-off low power selected before wake
// (RULE15) Serial reset request flag survives reset
// (RULE16) Debug exit on low debug pin flag
// (RULE17) Read during fault keeps flag set
// (RULE18) Read returns value then clears; set wins
module flag_latch
    import flag_latch_pkg::*;
#(
    parameter int unsigned STUCK_CYCLES = SELECT_STUCK_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic power_on_reset,
    input wire logic reset_by_serial_request,
    input wire fault_t fault_async,
    input wire event_t events,
    input wire logic serial_select_n,
    input wire logic debug_select_pin_low,
    input wire logic lowpower_regulator_on,
    input wire logic flash_mode,
    input wire logic [15:0] wdog_count,
    input wire logic [15:0] wdog_length,
    input wire logic [3:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [3:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic irq
);

    fault_t fault_meta_q, fault_q;
    logic sel_meta_q, sel_n_q, dbg_meta_q, dbg_low_q;
    logic [31:0] stuck_cnt_q;
    logic stuck_set;
    logic half_q;
    logic half_now;
    logic [15:0] flags_q, mask_q, cond, set_vec, clr_vec;
    logic rd_take, rd_flags;
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q, irq_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic [3:0] awaddr_q;
    logic aw_have_q, w_have_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;

    // Two-stage synchronisers for asynchronous levels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fault_meta_q <= '0;
            fault_q <= '0;
            sel_meta_q <= 1'b1;
            sel_n_q <= 1'b1;
            dbg_meta_q <= 1'b0;
            dbg_low_q <= 1'b0;
        end else begin
            fault_meta_q <= fault_async;
            fault_q <= fault_meta_q;
            sel_meta_q <= serial_select_n;
            sel_n_q <= sel_meta_q;
            dbg_meta_q <= debug_select_pin_low;
            dbg_low_q <= dbg_meta_q;
        end
    end

    // Counter saturates so one stuck period gives one set pulse
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stuck_cnt_q <= 32'h00000000;
        end else if (sel_n_q) begin
            stuck_cnt_q <= 32'h00000000;
        end else if (stuck_cnt_q <= STUCK_CYCLES) begin
            stuck_cnt_q <= stuck_cnt_q + 32'h00000001;
        end
    end
    assign stuck_set = !sel_n_q && (stuck_cnt_q == STUCK_CYCLES); // RULE4

    // Edge of the half-period crossing, so a read is not undone at once
    assign half_now = flash_mode &&
        ({wdog_count, 1'b0} > {1'b0, wdog_length}); // RULE8
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            half_q <= 1'b0;
        end else begin
            half_q <= half_now;
        end
    end

    // Live condition view; fault levels keep their flags set
    always_comb begin
        cond = 16'h0000;
        cond[HS3_SHORT_BIT] = fault_q.high_side_switch_three_short; // RULE1
        cond[HS2_SHORT_BIT] = fault_q.high_side_switch_two_short; // RULE2
        cond[SUPPLY2_UV_BIT] = fault_q.supply_input_two_low; // RULE5
        cond[SUPPLY1_OV_BIT] = fault_q.supply_input_one_high; // RULE6
        cond[IO0_THERMAL_BIT] = fault_q.io0_over_temp; // RULE7
        cond[SELECT_STUCK_BIT] = !sel_n_q;
        cond[WDOG_HALF_BIT] = half_now;
        cond[DEBUG_EXIT_BIT] = dbg_low_q;
    end

    always_comb begin
        set_vec = cond & FAULT_BITS; // RULE17
        set_vec[PARITY_BIT] = events.parity_error; // RULE3
        set_vec[SELECT_STUCK_BIT] = stuck_set; // RULE4
        set_vec[WDOG_HALF_BIT] = half_now && !half_q; // RULE8
        set_vec[WAKE_IO13_BIT] = events.wake_io13; // RULE9
        set_vec[WAKE_IO02_BIT] = events.wake_io02; // RULE10
        set_vec[SPI_WAKE_BIT] =
            events.spi_wake && lowpower_regulator_on; // RULE11
        set_vec[FORCED_WAKE_BIT] = events.forced_wakeup; // RULE12
        set_vec[INT_TIMEOUT_BIT] = events.int_timeout; // RULE13
        set_vec[LP_REG_OFF_BIT] = events.lowpower_regulator_off; // RULE14
        set_vec[RESET_REQ_BIT] = 1'b0;
        set_vec[DEBUG_EXIT_BIT] = events.debug_exit && dbg_low_q; // RULE16
    end

    assign rd_take = arvalid && arready_q;
    assign rd_flags = rd_take && (araddr[3:2] == FLAGS_OFFSET[3:2]);
    assign clr_vec = rd_flags ? 16'hFFFF : 16'h0000;

    // Set wins over the read clear in the same cycle
    genvar gi;
    generate
        for (gi = 0; gi < FLAG_COUNT; gi++) begin : g_flag
            if (gi == RESET_REQ_BIT) begin : g_keep
                // Not cleared by aresetn so the cause outlives the reset
                always_ff @(posedge aclk) begin
                    if (power_on_reset) begin
                        flags_q[gi] <= 1'b0;
                    end else if (!aresetn) begin
                        if (reset_by_serial_request) begin
                            flags_q[gi] <= 1'b1; // RULE15
                        end
                    end else if (clr_vec[gi]) begin
                        flags_q[gi] <= 1'b0; // RULE15
                    end
                end
            end else begin : g_plain
                always_ff @(posedge aclk) begin
                    if (!aresetn) begin
                        flags_q[gi] <= FLAGS_RESET[gi];
                    end else begin
                        flags_q[gi] <= (flags_q[gi] & ~clr_vec[gi]) |
                            set_vec[gi]; // RULE18
                    end
                end
            end
        end
    endgenerate

    // Write channel: address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 4'h0;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else begin
            if (awvalid && awready_q) begin
                awaddr_q <= awaddr;
                aw_have_q <= 1'b1;
                awready_q <= 1'b0;
            end
            if (wvalid && wready_q) begin
                wdata_q <= wdata;
                wstrb_q <= wstrb;
                w_have_q <= 1'b1;
                wready_q <= 1'b0;
            end
            if (aw_have_q && w_have_q && !bvalid_q) begin
                bvalid_q <= 1'b1;
                bresp_q <= (awaddr_q[3:2] <= COND_OFFSET[3:2]) ?
                    RESP_OKAY : RESP_SLVERR;
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
            end
            if (bvalid_q && bready) begin
                bvalid_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_q <= MASK_RESET;
        end else if (aw_have_q && w_have_q && !bvalid_q &&
                (awaddr_q[3:2] == MASK_OFFSET[3:2])) begin
            if (wstrb_q[0]) begin
                mask_q[7:0] <= wdata_q[7:0];
            end
            if (wstrb_q[1]) begin
                mask_q[15:8] <= wdata_q[15:8];
            end
        end
    end

    // Read channel: flag value captured before the clear lands
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= RESP_OKAY;
        end else if (rd_take) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rresp_q <= RESP_OKAY;
            case (araddr[3:2])
                FLAGS_OFFSET[3:2]: rdata_q <= {16'h0000, flags_q}; // RULE18
                MASK_OFFSET[3:2]: rdata_q <= {16'h0000, mask_q};
                COND_OFFSET[3:2]: rdata_q <= {16'h0000, cond};
                default: begin
                    rdata_q <= 32'h00000000;
                    rresp_q <= RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && rready) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(flags_q & mask_q);
        end
    end

    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign irq = irq_q;

    a_fault_holds: assert property ( // RULE1
        @(posedge aclk) disable iff (!aresetn)
        fault_q.high_side_switch_three_short |=> flags_q[HS3_SHORT_BIT])
        else $error("switch three flag dropped during short");

    a_fault_two_holds: assert property ( // RULE2
        @(posedge aclk) disable iff (!aresetn)
        fault_q.high_side_switch_two_short && rd_flags
        |=> flags_q[HS2_SHORT_BIT])
        else $error("switch two flag cleared by read while short");

    a_parity_read_clear: assert property ( // RULE3
        @(posedge aclk) disable iff (!aresetn)
        rd_flags && !events.parity_error |=> !flags_q[PARITY_BIT])
        else $error("parity flag survived a read");

    a_stuck_select: assert property ( // RULE4
        @(posedge aclk) disable iff (!aresetn)
        stuck_set |=> flags_q[SELECT_STUCK_BIT])
        else $error("stuck select not latched");

    a_undervolt_holds: assert property ( // RULE5
        @(posedge aclk) disable iff (!aresetn)
        fault_q.supply_input_two_low |=> flags_q[SUPPLY2_UV_BIT])
        else $error("undervoltage flag dropped during fault");

    a_supply_fault_release: assert property ( // RULE5
        @(posedge aclk) disable iff (!aresetn)
        rd_flags && !cond[SUPPLY2_UV_BIT] && !cond[SUPPLY1_OV_BIT]
        |=> !flags_q[SUPPLY2_UV_BIT] && !flags_q[SUPPLY1_OV_BIT])
        else $error("supply flag not released");

    a_overvolt_holds: assert property ( // RULE6
        @(posedge aclk) disable iff (!aresetn)
        fault_q.supply_input_one_high |=> flags_q[SUPPLY1_OV_BIT])
        else $error("overvoltage flag dropped during fault");

    a_thermal_holds: assert property ( // RULE7
        @(posedge aclk) disable iff (!aresetn)
        fault_q.io0_over_temp |=> flags_q[IO0_THERMAL_BIT])
        else $error("thermal flag dropped while hot");

    a_thermal_sticky: assert property ( // RULE7
        @(posedge aclk) disable iff (!aresetn)
        $fell(fault_q.io0_over_temp) && !rd_flags
        |=> flags_q[IO0_THERMAL_BIT])
        else $error("thermal flag lost without read");

    a_wdog_half: assert property ( // RULE8
        @(posedge aclk) disable iff (!aresetn)
        half_now && !half_q |=> flags_q[WDOG_HALF_BIT])
        else $error("watchdog half flag not set");

    a_wake_pair_set: assert property ( // RULE10
        @(posedge aclk) disable iff (!aresetn)
        events.wake_io02 |=> flags_q[WAKE_IO02_BIT])
        else $error("pin zero or two wake not latched");

    a_spi_wake_gate: assert property ( // RULE11
        @(posedge aclk) disable iff (!aresetn)
        events.spi_wake && !lowpower_regulator_on && !flags_q[SPI_WAKE_BIT]
        |=> !flags_q[SPI_WAKE_BIT])
        else $error("serial wake flagged with regulator off");

    a_read_returns_flag: assert property ( // RULE12
        @(posedge aclk) disable iff (!aresetn)
        rd_flags && flags_q[FORCED_WAKE_BIT]
        |=> rvalid_q && rdata_q[FORCED_WAKE_BIT])
        else $error("read lost forced wake flag");

    a_int_timeout_set: assert property ( // RULE13
        @(posedge aclk) disable iff (!aresetn)
        events.int_timeout |=> flags_q[INT_TIMEOUT_BIT])
        else $error("service timeout not latched");

    a_lp_off_set: assert property ( // RULE14
        @(posedge aclk) disable iff (!aresetn)
        events.lowpower_regulator_off |=> flags_q[LP_REG_OFF_BIT])
        else $error("regulator-off low power not latched");

    a_reset_req_clear: assert property ( // RULE15
        @(posedge aclk) disable iff (!aresetn)
        rd_flags |=> !flags_q[RESET_REQ_BIT])
        else $error("reset request flag survived a read");

    a_debug_exit_gate: assert property ( // RULE16
        @(posedge aclk) disable iff (!aresetn)
        events.debug_exit && !dbg_low_q && !flags_q[DEBUG_EXIT_BIT]
        |=> !flags_q[DEBUG_EXIT_BIT])
        else $error("debug exit flagged with pin high");

    a_fault_read_view: assert property ( // RULE17
        @(posedge aclk) disable iff (!aresetn)
        rd_flags
        |=> (flags_q & FAULT_BITS) == ($past(cond) & FAULT_BITS))
        else $error("fault flags not following condition on read");

    a_wake_set_wins: assert property ( // RULE18
        @(posedge aclk) disable iff (!aresetn)
        events.wake_io13 && rd_flags |=> flags_q[WAKE_IO13_BIT])
        else $error("wake event lost to clear");

    a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
        |(flags_q & mask_q) |=> irq_q)
        else $error("interrupt not raised");

endmodule : flag_latch

`default_nettype wire

// File: logic/flag_latch_pkg.sv
// Constants and carrier types for the status flag latch block.
// Assumes a single 20 MHz clock and an AXI4-Lite master with 32-bit data.
package flag_latch_pkg;

    localparam int CLK_FREQ_KHZ = 20000;
    localparam int SELECT_STUCK_TIME_US = 2000;
    // Least time: round up to whole cycles
    localparam int SELECT_STUCK_CYCLES =
        (SELECT_STUCK_TIME_US * CLK_FREQ_KHZ + 999) / 1000;

    localparam int FLAG_COUNT = 16;

    // Register byte addresses
    localparam logic [3:0] FLAGS_OFFSET = 4'h0;
    localparam logic [3:0] MASK_OFFSET = 4'h4;
    localparam logic [3:0] COND_OFFSET = 4'h8;

    localparam logic [15:0] MASK_RESET = 16'h0000;
    localparam logic [15:0] FLAGS_RESET = 16'h0000;

    // Flag bit positions
    localparam int HS3_SHORT_BIT = 0;
    localparam int HS2_SHORT_BIT = 1;
    localparam int PARITY_BIT = 2;
    localparam int SELECT_STUCK_BIT = 3;
    localparam int SUPPLY2_UV_BIT = 4;
    localparam int SUPPLY1_OV_BIT = 5;
    localparam int IO0_THERMAL_BIT = 6;
    localparam int WDOG_HALF_BIT = 7;
    localparam int WAKE_IO13_BIT = 8;
    localparam int WAKE_IO02_BIT = 9;
    localparam int SPI_WAKE_BIT = 10;
    localparam int FORCED_WAKE_BIT = 11;
    localparam int INT_TIMEOUT_BIT = 12;
    localparam int LP_REG_OFF_BIT = 13;
    localparam int RESET_REQ_BIT = 14;
    localparam int DEBUG_EXIT_BIT = 15;

    // Flags that release only once their condition has gone
    localparam logic [15:0] FAULT_BITS = 16'h0073;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Analog fault levels, asynchronous to aclk
    typedef struct packed {
        logic high_side_switch_three_short;
        logic high_side_switch_two_short;
        logic supply_input_two_low;
        logic supply_input_one_high;
        logic io0_over_temp;
    } fault_t;

    // One-cycle event pulses from logic on aclk
    typedef struct packed {
        logic parity_error;
        logic wake_io13;
        logic wake_io02;
        logic spi_wake;
        logic forced_wakeup;
        logic int_timeout;
        logic lowpower_regulator_off;
        logic debug_exit;
    } event_t;

endpackage : flag_latch_pkg

// File: testbench/axi_host.sv
// AXI4-Lite master standing in for the host microcontroller.
// Assumes one request pulse from the bench per transfer, never while busy.
`timescale 1ns/1ps
`default_nettype none
module axi_host (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic req,
    input wire logic wr,
    input wire logic [3:0] addr,
    input wire logic [31:0] data,
    output logic done,
    output logic [31:0] rd,
    output logic [1:0] resp,
    output logic [3:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [3:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    assign wstrb = 4'hF;
    always_ff @(posedge aclk) begin
        done <= 1'b0;
        if (!aresetn) begin
            {awvalid, wvalid, arvalid, bready, rready} <= 5'h00;
            {awaddr, araddr, wdata} <= 40'h00_0000_0000;
        end else if (req) begin
            awaddr <= addr;
            araddr <= addr;
            wdata <= data;
            {awvalid, wvalid, bready} <= {3{wr}};
            {arvalid, rready} <= {2{!wr}};
        end else begin
            // Released payloads flip so stale values cannot pass
            if (awvalid && awready) begin
                awvalid <= 1'b0;
                awaddr <= ~awaddr;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                wdata <= ~wdata;
            end
            if (arvalid && arready) begin
                arvalid <= 1'b0;
                araddr <= ~araddr;
            end
            if (bvalid && bready) begin
                bready <= 1'b0;
                resp <= bresp;
                done <= 1'b1;
            end
            if (rvalid && rready) begin
                rready <= 1'b0;
                resp <= rresp;
                rd <= rdata;
                done <= 1'b1;
            end
        end
    end
endmodule : axi_host
`default_nettype wire

// File: testbench/tb_flag_latch.sv
// Bench for the flag latches: faults, events, timers, mask, interrupt.
// Assumes the host model performs every register access.
`timescale 1ns/1ps
`default_nettype none
module tb_flag_latch;
    import flag_latch_pkg::*;
    localparam int STK = 20;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic power_on_reset = 1'b1;
    logic reset_by_serial_request = 1'b0;
    fault_t fault_async = '0;
    event_t events = '0;
    logic serial_select_n = 1'b1;
    logic debug_select_pin_low = 1'b0;
    logic lowpower_regulator_on = 1'b0;
    logic flash_mode = 1'b0;
    logic [15:0] wdog_count = 16'h0000;
    logic [15:0] wdog_length = 16'h0064;
    logic req = 1'b0;
    logic wr = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] data = 32'h0000_0000;
    logic done, irq, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata, rd;
    logic [1:0] bresp, rresp, resp;
    int errors = 0;
    int cmp_count = 0;

    flag_latch #(.STUCK_CYCLES(STK)) flag_latch_i (.aclk, .aresetn,
        .power_on_reset, .reset_by_serial_request, .fault_async, .events,
        .serial_select_n, .debug_select_pin_low, .lowpower_regulator_on,
        .flash_mode, .wdog_count, .wdog_length, .awaddr, .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .irq);
    axi_host axi_host_i (.aclk, .aresetn, .req, .wr, .addr, .data, .done,
        .rd, .resp, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
        .rdata, .rresp, .rvalid, .rready);

    initial begin
        forever #25 aclk = ~aclk;
    end

    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t word %h want %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t irq %b want %b", $time, got, exp);
        end
    endtask : chk_bit

    task automatic idle(input int n);
        repeat (n) @(posedge aclk);
    endtask : idle

    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge aclk);
        wr <= w;
        addr <= a;
        data <= d;
        req <= 1'b1;
        @(posedge aclk);
        req <= 1'b0;
        do begin
            @(posedge aclk);
            #1;
            n++;
        end while (done !== 1'b1 && n < 50);
        if (n >= 50) begin
            errors++;
            $display("BAD %0t bus transfer hung", $time);
            end_of_test();
        end
    endtask : bus

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk_word(rd, exp);
    endtask : rd_chk

    task automatic pulse(input logic [7:0] e);
        @(posedge aclk);
        events <= event_t'(e);
        @(posedge aclk);
        events <= '0;
        idle(3);
    endtask : pulse

    task automatic t_faults;
        int fb [5] = '{6, 5, 4, 1, 0};
        for (int i = 0; i < 5; i++) begin
            @(posedge aclk);
            fault_async <= fault_t'(5'h01 << i);
            idle(6);
            rd_chk(COND_OFFSET, 32'h1 << fb[i]);
            rd_chk(FLAGS_OFFSET, 32'h1 << fb[i]);
            rd_chk(FLAGS_OFFSET, 32'h1 << fb[i]);
            @(posedge aclk);
            fault_async <= '0;
            idle(6);
            rd_chk(FLAGS_OFFSET, 32'h1 << fb[i]);
            rd_chk(FLAGS_OFFSET, 32'h0);
        end
    endtask : t_faults

    task automatic t_events;
        int eb [8] = '{15, 13, 12, 11, 10, 9, 8, 2};
        @(posedge aclk);
        lowpower_regulator_on <= 1'b1;
        debug_select_pin_low <= 1'b1;
        idle(6);
        for (int i = 0; i < 8; i++) begin
            pulse(8'h01 << i);
            rd_chk(FLAGS_OFFSET, 32'h1 << eb[i]);
            rd_chk(FLAGS_OFFSET, 32'h0);
        end
        @(posedge aclk);
        lowpower_regulator_on <= 1'b0;
        debug_select_pin_low <= 1'b0;
        idle(4);
        pulse(8'h11);
        rd_chk(FLAGS_OFFSET, 32'h0);
    endtask : t_events

    // Wake pulse lands on the very edge the read is taken
    task automatic t_set_wins;
        fork
            rd_chk(FLAGS_OFFSET, 32'h0);
            begin
                idle(2);
                events <= event_t'(8'h40);
                @(posedge aclk);
                events <= '0;
            end
        join
        rd_chk(FLAGS_OFFSET, 32'h100);
    endtask : t_set_wins

    task automatic t_timers;
        @(posedge aclk);
        serial_select_n <= 1'b0;
        idle(STK - 6);
        serial_select_n <= 1'b1;
        idle(6);
        rd_chk(FLAGS_OFFSET, 32'h0);
        @(posedge aclk);
        serial_select_n <= 1'b0;
        idle(STK + 6);
        serial_select_n <= 1'b1;
        idle(4);
        rd_chk(FLAGS_OFFSET, 32'h8);
        rd_chk(FLAGS_OFFSET, 32'h0);
        @(posedge aclk);
        flash_mode <= 1'b1;
        wdog_count <= 16'h0032;
        idle(4);
        rd_chk(FLAGS_OFFSET, 32'h0);
        @(posedge aclk);
        wdog_count <= 16'h0033;
        idle(4);
        rd_chk(FLAGS_OFFSET, 32'h80);
        rd_chk(FLAGS_OFFSET, 32'h0);
        @(posedge aclk);
        flash_mode <= 1'b0;
    endtask : t_timers

    task automatic t_irq_bus;
        bus(1'b1, MASK_OFFSET, 32'h0000_0004);
        rd_chk(MASK_OFFSET, 32'h4);
        pulse(8'h80);
        chk_bit(irq, 1'b1);
        rd_chk(FLAGS_OFFSET, 32'h4);
        idle(3);
        #1;
        chk_bit(irq, 1'b0);
        pulse(8'h40);
        #1;
        chk_bit(irq, 1'b0);
        rd_chk(FLAGS_OFFSET, 32'h100);
        bus(1'b1, 4'hC, 32'h0000_FFFF);
        chk_word({30'h0, resp}, {30'h0, RESP_SLVERR});
        rd_chk(4'hC, 32'h0);
        chk_word({30'h0, resp}, {30'h0, RESP_SLVERR});
        bus(1'b1, FLAGS_OFFSET, 32'h0000_FFFF);
        rd_chk(FLAGS_OFFSET, 32'h0);
    endtask : t_irq_bus

    task automatic t_reset_req;
        @(posedge aclk);
        aresetn <= 1'b0;
        reset_by_serial_request <= 1'b1;
        idle(3);
        aresetn <= 1'b1;
        reset_by_serial_request <= 1'b0;
        rd_chk(MASK_OFFSET, {16'h0, MASK_RESET});
        rd_chk(FLAGS_OFFSET, 32'h4000);
        rd_chk(FLAGS_OFFSET, 32'h0);
    endtask : t_reset_req

    initial begin
        idle(3);
        aresetn <= 1'b1;
        power_on_reset <= 1'b0;
        rd_chk(FLAGS_OFFSET, {16'h0, FLAGS_RESET});
        t_faults();
        t_events();
        t_set_wins();
        t_timers();
        t_irq_bus();
        t_reset_req();
        end_of_test();
    end

    // Whole run needs under 2000 cycles
    initial begin
        #500000;
        errors++;
        $display("BAD %0t run did not finish", $time);
        end_of_test();
    end
endmodule : tb_flag_latch
`default_nettype wire
